// [dv/tap_controller_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_controller_checker
    import tap_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic tap_enable_fuse,
    input wire logic tap_disable_bit,
    input wire logic tdo_oe_n,
    input wire logic pins_are_port,
    input wire logic pullup_en,
    input wire logic extest_active,
    input wire logic prog_active,
    input wire logic dbg_active,
    input wire logic idle_run,
    input wire logic [IR_WIDTH-1:0] instruction
);
    // ****
    // port relations
    // ****
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    pull_level_a: assert property (pullup_en == (tap_enable_fuse && !tap_disable_bit))
        else $error("pullup level wrong");
    port_mode_a: assert property (pins_are_port == !(tap_enable_fuse && !tap_disable_bit))
        else $error("port mode wrong");
    one_chain_a: assert property ($onehot0({extest_active, prog_active, dbg_active}))
        else $error("two chains active");
    extest_sel_a: assert property (extest_active == (instruction == INS_EXTEST))
        else $error("extest select wrong");
    prog_sel_a: assert property (prog_active == (instruction inside {[4'h4:4'h7]}))
        else $error("prog select wrong");
    dbg_sel_a: assert property (dbg_active == (instruction inside {[4'h8:4'hB]}))
        else $error("debug select wrong");
    reset_load_a: assert property (disable iff (1'b0) !rstn |=> instruction == IR_RESET && tdo_oe_n)
        else $error("reset values wrong");
    disable_hold_a: assert property (pins_are_port [*3] |-> instruction == IR_RESET && !idle_run && tdo_oe_n)
        else $error("tap not held in reset");
    update_quiet_a: assert property (pullup_en && $changed(instruction) |-> tdo_oe_n)
        else $error("instruction changed in shift");
    idle_quiet_a: assert property (idle_run |-> tdo_oe_n)
        else $error("tdo driven in idle");
    cover property (extest_active ##1 !tdo_oe_n);
    cover property (prog_active && !tdo_oe_n);
    cover property (dbg_active && !tdo_oe_n);
    cover property ($fell(pullup_en));
endmodule
bind tap_controller tap_controller_checker chk (.*);
`default_nettype wire

// [dv/tap_controller_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_controller_tb
    import tap_pkg::*;
();
    logic clock, rstn, tap_enable_fuse, tap_disable_bit, tck, tms, tdi, tdo, tdo_oe_n;
    logic pins_are_port, pullup_en, extest_active, prog_active, dbg_active, idle_run;
    logic [BSR_WIDTH-1:0] bsr_pins_in, bsr_pins_out, bsr_e;
    logic [PROG_WIDTH-1:0] prog_in, prog_out, prog_e;
    logic [DBG_WIDTH-1:0] dbg_in, dbg_out, dbg_e;
    logic [IR_WIDTH-1:0] instruction, k;
    logic [31:0] d, q;
    logic tdo_pin;
    int failures, comparisons, seed;
    tap_controller dut (.*);
    // released tdo shows the inverse so that a late enable is caught
    assign tdo_pin = tdo_oe_n ? !tdo : tdo;
    tap_host host (.clock(clock), .tdo(tdo_pin), .tck(tck), .tms(tms), .tdi(tdi));
    // ****
    // expectations and checking
    // ****
    function automatic int width_of(input logic [3:0] c);
        if (c == INS_IDCODE) return ID_WIDTH;
        if (c == INS_EXTEST || c == INS_SAMPLE) return BSR_WIDTH;
        if (c >= INS_PROG_FIRST && c <= INS_DEBUG_LAST) return PROG_WIDTH;
        return 8;
    endfunction
    function automatic logic [31:0] cap_of(input logic [3:0] c, input logic [31:0] v);
        if (c == INS_IDCODE) return ID_VALUE;
        if (c == INS_EXTEST || c == INS_SAMPLE) return 32'(bsr_pins_in);
        if (c >= INS_PROG_FIRST && c <= INS_PROG_LAST) return 32'(prog_in);
        if (c >= INS_DEBUG_FIRST && c <= INS_DEBUG_LAST) return 32'(dbg_in);
        return {24'h0, v[6:0], 1'b0};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #3000000;
        failures++;
        finish_test();
    end
    initial begin
        seed = 29920;
        {rstn, tap_disable_bit, tap_enable_fuse} = 3'h1;
        {bsr_pins_in, prog_in, dbg_in, bsr_e, prog_e, dbg_e} = '0;
        repeat (3) @(posedge clock);
        #1;
        rstn = 1'b1;
        check({instruction, tdo_oe_n, pullup_en}, {IR_RESET, 2'h3});
        host.walk(8'h00, 1);
        for (int c = 0; c < 16; c++) begin
            k = c[3:0];
            bsr_pins_in = $random(seed);
            prog_in = $random(seed);
            dbg_in = $random(seed);
            d = $random(seed);
            if (k == INS_SAMPLE) d[BSR_WIDTH-1:0] = bsr_e;
            host.load_ir(k, q);
            check(q, 32'(IR_CAPTURE));
            check(instruction, k);
            check({extest_active, prog_active, dbg_active}, {k == 4'h0, k[3:2] == 2'h1, k[3:2] == 2'h2});
            host.scan_dr(width_of(k), d, q);
            check(q, cap_of(k, d));
            if (k == INS_EXTEST) bsr_e = d[BSR_WIDTH-1:0];
            if (k[3:2] == 2'h1) prog_e = d[PROG_WIDTH-1:0];
            if (k[3:2] == 2'h2) dbg_e = d[DBG_WIDTH-1:0];
            check({bsr_pins_out, prog_out, dbg_out, idle_run}, {bsr_e, prog_e, dbg_e, 1'b1});
        end
        host.walk(8'h01, 3);
        host.walk(8'h1F, 6);
        check({instruction, idle_run}, {IR_RESET, 1'b1});
        host.load_ir(INS_BYPASS, q);
        tap_enable_fuse = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({pins_are_port, pullup_en, tdo_oe_n, instruction}, {3'h5, IR_RESET});
        {tap_enable_fuse, tap_disable_bit} = 2'h3;
        #1;
        check({pins_are_port, pullup_en}, 2'h2);
        tap_disable_bit = 1'b0;
        host.walk(8'h00, 1);
        host.load_ir(INS_EXTEST, q);
        rstn = 1'b0;
        @(posedge clock);
        #1;
        rstn = 1'b1;
        check({instruction, bsr_pins_out}, {IR_RESET, 8'h00});
        finish_test();
    end
endmodule
`default_nettype wire

// [dv/tap_host.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_host (
    input wire logic clock,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // ****
    // test controller: tck low between steps
    // ****
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic step(input logic m, input logic v, output logic o);
        @(posedge clock);
        #1;
        tms = m;
        tdi = v;
        repeat (3) @(posedge clock);
        #1;
        o = tdo;
        tck = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        tck = 1'b0;
        tdi = ~v;
    endtask
    task automatic walk(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(m[i], 1'b0, o);
        end
    endtask
    task automatic shift(input int n, input logic [31:0] v, output logic [31:0] q);
        logic o;
        q = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], o);
            q[i] = o;
        end
        walk(8'h01, 2);
    endtask
    task automatic load_ir(input logic [3:0] c, output logic [31:0] q);
        walk(8'h03, 4);
        shift(4, 32'(c), q);
    endtask
    task automatic scan_dr(input int n, input logic [31:0] v, output logic [31:0] q);
        walk(8'h01, 3);
        shift(n, v, q);
    endtask
endmodule
`default_nettype wire

// [logic/tap_chain.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_chain #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic tck_rise,
    input wire logic sel,
    tap_shift_if.chain sif,
    input wire logic [WIDTH-1:0] par_in,
    output logic [WIDTH-1:0] par_out,
    output logic ser_out
);
    logic [WIDTH-1:0] sr_q;

    // ***********************************************
    // capture, shift and latched update
    // ***********************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sr_q <= '0;
        end else if (tck_rise && sel && sif.capture) begin
            sr_q <= par_in; // [R12]
        end else if (tck_rise && sel && sif.shift) begin
            sr_q <= {sif.tdi, sr_q[WIDTH-1:1]}; // [R6]
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            par_out <= '0;
        end else if (tck_rise && sel && sif.update) begin
            par_out <= sr_q; // [R13]
        end
    end

    assign ser_out = sr_q[0]; // [R6]
endmodule
`default_nettype wire

// [logic/tap_controller.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] fuse off: pins free, tap held reset
// [R2] fuse on, disable clear: pullups, access on
// [R3] no trst; only tms resets
// [R4] sixteen states, tms sampled on tck rise
// [R5] power-on reset starts in test-logic-reset
// [R6] all shifts move lsb first
// [R7] host uses 1,1,0,0 to shift-ir
// [R8] four-bit ir, tms high with msb
// [R9] shift-ir outputs captured value 0x01
// [R10] update-ir latches new instruction
// [R11] host uses 1,0,0 to shift-dr
// [R12] capture-dr loads, then shifts out
// [R13] latched outputs change only in update-dr
// [R14] exit and pause states do nothing
// [R15] five tms highs reach reset
// [R16] instruction picks exactly one data register
// [R17] id, bypass, boundary, program, debug chains
// [R18] idle between ir and dr optional
// [R19] debugger watches and pulls system reset; no reset output here, debug chain only captures dbg_in, drives dbg_out
// [R20] tck-synchronous; tdo from shifted register
// [R21] standard graph; tdo on fall, hi-z elsewhere
// [R22] reset loads default instruction
module tap_controller
    import tap_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic tap_enable_fuse,
    input wire logic tap_disable_bit,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic pins_are_port,
    output logic pullup_en,
    input wire logic [BSR_WIDTH-1:0] bsr_pins_in,
    output logic [BSR_WIDTH-1:0] bsr_pins_out,
    output logic extest_active,
    input wire logic [PROG_WIDTH-1:0] prog_in,
    output logic [PROG_WIDTH-1:0] prog_out,
    output logic prog_active,
    input wire logic [DBG_WIDTH-1:0] dbg_in,
    output logic [DBG_WIDTH-1:0] dbg_out,
    output logic dbg_active,
    output logic idle_run,
    output logic [IR_WIDTH-1:0] instruction
);
    // ***********************************************
    // pin synchronisers and tck edges
    // ***********************************************
    logic [1:0] tck_s_q;
    logic [1:0] tms_s_q;
    logic [1:0] tdi_s_q;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;
    logic tap_on;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tck_s_q <= 2'h0;
            tck_prev_q <= 1'b0;
        end else begin
            tck_s_q <= {tck_s_q[0], tck};
            tck_prev_q <= tck_s_q[1];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tms_s_q <= 2'h3;
        end else begin
            tms_s_q <= {tms_s_q[0], tms};
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tdi_s_q <= 2'h3;
        end else begin
            tdi_s_q <= {tdi_s_q[0], tdi};
        end
    end

    assign tck_rise = tck_s_q[1] && !tck_prev_q; // [R20]
    assign tck_fall = !tck_s_q[1] && tck_prev_q; // [R21]
    assign tap_on = tap_enable_fuse && !tap_disable_bit; // [R2]
    assign pins_are_port = !tap_on; // [R1]
    assign pullup_en = tap_on; // [R2]

    // ***********************************************
    // tap state machine
    // ***********************************************
    tap_state_t state_q;
    tap_state_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q) // [R21]
            st_reset: state_d = tms_s_q[1] ? st_reset : st_idle;
            st_idle: state_d = tms_s_q[1] ? st_sel_dr : st_idle; // [R18]
            st_sel_dr: state_d = tms_s_q[1] ? st_sel_ir : st_cap_dr;
            st_cap_dr: state_d = tms_s_q[1] ? st_exit1_dr : st_shift_dr;
            st_shift_dr: state_d = tms_s_q[1] ? st_exit1_dr : st_shift_dr;
            st_exit1_dr: state_d = tms_s_q[1] ? st_upd_dr : st_pause_dr;
            st_pause_dr: state_d = tms_s_q[1] ? st_exit2_dr : st_pause_dr;
            st_exit2_dr: state_d = tms_s_q[1] ? st_upd_dr : st_shift_dr;
            st_upd_dr: state_d = tms_s_q[1] ? st_sel_dr : st_idle;
            st_sel_ir: state_d = tms_s_q[1] ? st_reset : st_cap_ir; // [R15]
            st_cap_ir: state_d = tms_s_q[1] ? st_exit1_ir : st_shift_ir;
            st_shift_ir: state_d = tms_s_q[1] ? st_exit1_ir : st_shift_ir;
            st_exit1_ir: state_d = tms_s_q[1] ? st_upd_ir : st_pause_ir;
            st_pause_ir: state_d = tms_s_q[1] ? st_exit2_ir : st_pause_ir;
            st_exit2_ir: state_d = tms_s_q[1] ? st_upd_ir : st_shift_ir;
            st_upd_ir: state_d = tms_s_q[1] ? st_sel_dr : st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn || !tap_on) begin
            state_q <= st_reset; // [R1] [R3] [R5]
        end else if (tck_rise) begin
            state_q <= state_d; // [R4]
        end
    end

    // ***********************************************
    // instruction register
    // ***********************************************
    logic [IR_WIDTH-1:0] ir_sr_q;
    logic [IR_WIDTH-1:0] ir_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (tck_rise && state_q == st_cap_ir) begin
            ir_sr_q <= IR_CAPTURE; // [R9]
        end else if (tck_rise && state_q == st_shift_ir) begin
            ir_sr_q <= {tdi_s_q[1], ir_sr_q[IR_WIDTH-1:1]}; // [R6]
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || state_q == st_reset) begin
            ir_q <= IR_RESET; // [R22]
        end else if (tck_rise && state_q == st_upd_ir) begin
            ir_q <= ir_sr_q; // [R10]
        end
    end

    assign instruction = ir_q;

    // ***********************************************
    // instruction decode
    // ***********************************************
    function automatic logic in_band(input logic [IR_WIDTH-1:0] c, lo, hi);
        return c >= lo && c <= hi;
    endfunction

    // ***********************************************
    // data register selection
    // ***********************************************
    logic sel_id;
    logic sel_bsr;
    logic sel_prog;
    logic sel_dbg;
    logic sel_byp;

    always_comb begin
        sel_id = 1'b0;
        sel_bsr = 1'b0;
        sel_prog = 1'b0;
        sel_dbg = 1'b0;
        sel_byp = 1'b0;
        if (ir_q == INS_IDCODE) begin
            sel_id = 1'b1; // [R16] [R17]
        end else if (ir_q == INS_EXTEST || ir_q == INS_SAMPLE) begin
            sel_bsr = 1'b1;
        end else if (in_band(ir_q, INS_PROG_FIRST, INS_PROG_LAST)) begin
            sel_prog = 1'b1;
        end else if (in_band(ir_q, INS_DEBUG_FIRST, INS_DEBUG_LAST)) begin
            sel_dbg = 1'b1;
        end else begin
            sel_byp = 1'b1;
        end
    end

    assign extest_active = sel_bsr && ir_q == INS_EXTEST;
    assign prog_active = sel_prog;
    assign dbg_active = sel_dbg;
    assign idle_run = state_q == st_idle; // [R18]

    // ***********************************************
    // shared control to chains; exit and pause states idle
    // ***********************************************
    tap_shift_if sif ();
    assign sif.capture = state_q == st_cap_dr; // [R12]
    assign sif.shift = state_q == st_shift_dr; // [R14]
    assign sif.update = state_q == st_upd_dr; // [R13]
    assign sif.tdi = tdi_s_q[1];

    logic id_so;
    logic bsr_so;
    logic prog_so;
    logic dbg_so;

    tap_chain #(.WIDTH(ID_WIDTH)) u_id (
        .clock(clock),
        .rstn(rstn),
        .tck_rise(tck_rise),
        .sel(sel_id),
        .sif(sif),
        .par_in(ID_VALUE),
        .par_out(),
        .ser_out(id_so)
    );

    tap_chain #(.WIDTH(BSR_WIDTH)) u_bsr (
        .clock(clock),
        .rstn(rstn),
        .tck_rise(tck_rise),
        .sel(sel_bsr),
        .sif(sif),
        .par_in(bsr_pins_in),
        .par_out(bsr_pins_out),
        .ser_out(bsr_so)
    );

    tap_chain #(.WIDTH(PROG_WIDTH)) u_prog (
        .clock(clock),
        .rstn(rstn),
        .tck_rise(tck_rise),
        .sel(sel_prog),
        .sif(sif),
        .par_in(prog_in),
        .par_out(prog_out),
        .ser_out(prog_so)
    );

    tap_chain #(.WIDTH(DBG_WIDTH)) u_dbg (
        .clock(clock),
        .rstn(rstn),
        .tck_rise(tck_rise),
        .sel(sel_dbg),
        .sif(sif),
        .par_in(dbg_in),
        .par_out(dbg_out),
        .ser_out(dbg_so)
    );

    // ***********************************************
    // bypass bit
    // ***********************************************
    logic byp_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            byp_q <= 1'b0;
        end else if (tck_rise && sel_byp && state_q == st_cap_dr) begin
            byp_q <= 1'b0;
        end else if (tck_rise && sel_byp && state_q == st_shift_dr) begin
            byp_q <= tdi_s_q[1];
        end
    end

    // ***********************************************
    // tdo on falling tck, released outside shift
    // ***********************************************
    logic dr_so;

    always_comb begin
        dr_so = byp_q;
        if (sel_id) begin
            dr_so = id_so;
        end else if (sel_bsr) begin
            dr_so = bsr_so;
        end else if (sel_prog) begin
            dr_so = prog_so;
        end else if (sel_dbg) begin
            dr_so = dbg_so;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tdo <= 1'b0;
        end else if (tck_fall) begin
            tdo <= (state_q == st_shift_ir) ? ir_sr_q[0] : dr_so; // [R20] [R21]
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || !tap_on) begin
            tdo_oe_n <= 1'b1; // [R1]
        end else if (tck_fall) begin
            tdo_oe_n <= !(state_q == st_shift_ir || state_q == st_shift_dr); // [R21]
        end
    end
endmodule
`default_nettype wire

// [logic/tap_pkg.sv]
package tap_pkg;
    // ***********************************************
    // tap states and instruction register
    // ***********************************************
    typedef enum logic [3:0] {
        st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr,
        st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir,
        st_pause_ir, st_exit2_ir, st_upd_ir
    } tap_state_t;

    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // instruction codes
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_IDCODE = 4'h1;
    localparam logic [3:0] INS_SAMPLE = 4'h2;
    localparam logic [3:0] INS_PROG_FIRST = 4'h4;
    localparam logic [3:0] INS_PROG_LAST = 4'h7;
    localparam logic [3:0] INS_DEBUG_FIRST = 4'h8;
    localparam logic [3:0] INS_DEBUG_LAST = 4'hB;
    localparam logic [3:0] INS_BYPASS = 4'hF;
    localparam logic [3:0] IR_RESET = INS_IDCODE;

    // ***********************************************
    // data register sizes
    // ***********************************************
    localparam int ID_WIDTH = 32;
    // arbitrary identity value
    localparam logic [31:0] ID_VALUE = 32'h0000_0001;
    localparam int BSR_WIDTH = 8;
    localparam int PROG_WIDTH = 16;
    localparam int DBG_WIDTH = 16;
endpackage

// [logic/tap_shift_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface tap_shift_if;
    logic capture;
    logic shift;
    logic update;
    logic tdi;
    modport ctrl (output capture, output shift, output update, output tdi);
    modport chain (input capture, input shift, input update, input tdi);
endinterface
`default_nettype wire
